/* File: hw/acc_pkg.sv */
// acc_pkg: constants for the converter control block
// assumes a 32-bit classic Wishbone slave with byte addresses
package acc_pkg;

  // register byte offsets
  localparam logic [7:0] ACC_OFS_CTRL0  = 8'h00;
  localparam logic [7:0] ACC_OFS_CTRL1  = 8'h04;
  localparam logic [7:0] ACC_OFS_RES_HI = 8'h08;
  localparam logic [7:0] ACC_OFS_RES_LO = 8'h0c;
  localparam logic [7:0] ACC_OFS_IRQ    = 8'h10;

  // converter_control_0 fields
  localparam int ACC_ON_BIT = 0;
  localparam int ACC_GO_BIT = 1;
  localparam int ACC_CH_LSB = 2;
  localparam int ACC_CH_W   = 5;

  // converter_control_1 fields
  localparam int ACC_CKS_LSB = 4;
  localparam int ACC_CKS_W   = 3;

  // flag / enable register fields
  localparam int ACC_FLAG_BIT = 0;
  localparam int ACC_IE_BIT   = 1;

  // result layout
  localparam int ACC_RES_W    = 10;
  localparam int ACC_RES_HI_W = 2;
  localparam int ACC_RES_LO_W = 8;

  // conversion clock select codes
  localparam logic [2:0] ACC_CKS_DIV8  = 3'h1;
  localparam logic [2:0] ACC_CKS_DIV16 = 3'h5;
  localparam logic [2:0] ACC_CKS_DIV32 = 3'h2;
  localparam logic [2:0] ACC_CKS_DIV64 = 3'h6;
  localparam logic [1:0] ACC_CKS_RC    = 2'h3;

  // system clock cycles per bit period, minus one
  localparam logic [5:0] ACC_TC_DIV8  = 6'h07;
  localparam logic [5:0] ACC_TC_DIV16 = 6'h0f;
  localparam logic [5:0] ACC_TC_DIV32 = 6'h1f;
  localparam logic [5:0] ACC_TC_DIV64 = 6'h3f;

  // internal oscillator ticks per rc bit period, minus one
  localparam logic [3:0] ACC_TC_RC = 4'hf;

  // bit periods per conversion, minus one; abort gap in bit periods
  localparam logic [3:0] ACC_LAST_STEP = 4'ha;
  localparam logic [1:0] ACC_ABORT_GAP = 2'h2;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_CONV  = 2'b01,
    ACC_ABORT = 2'b10
  } acc_state_e;

endpackage

/* File: hw/acc_top.sv */
// acc_top: control and status logic of a 10-bit successive-approximation converter
// assumes a classic Wishbone master, a synchronous comparator input and a
// one-cycle pulse per internal oscillator period on rc_tick_i
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module acc_top
  import acc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // analog front end
  input  wire logic              cmp_i,
  input  wire logic              rc_tick_i,
  output logic      [4:0]        channel_o,
  output logic      [9:0]        trial_code_o,
  output logic                   power_o,
  output logic                   acquire_o,
  output logic                   hold_o,
  // system
  input  wire logic              sleep_i,
  input  wire logic              global_irq_enable_i,
  input  wire logic              peripheral_irq_enable_i,
  output logic                   irq_o,
  output logic                   wake_o,
  output logic                   vector_o
);

  typedef struct packed {
    acc_state_e            state;
    logic [ACC_CH_W-1:0]   ch;
    logic [ACC_CKS_W-1:0]  cks;
    logic                  on;
    logic                  flag;
    logic                  ie;
    logic [ACC_RES_W-1:0]  res;
    logic [ACC_RES_W-1:0]  sar;
    logic [3:0]            step;
    logic [1:0]            gap;
    logic [5:0]            div;
    logic [3:0]            rcdiv;
    logic                  ack;
    logic [31:0]           dat;
    logic                  irq;
    logic                  wake;
    logic                  vec;
    logic                  acq;
    logic                  hold;
  } acc_s;

  localparam acc_s ACC_RESET = '{
    state: ACC_IDLE,
    default: '0
  };

  acc_s s_q;
  acc_s s_d;

  logic       req;
  logic       wr;
  logic       rc_sel;
  logic       fosc_run;
  logic       bit_tick;
  logic [5:0] tc;
  logic [3:0] idx;
  logic       done;

  assign req = cyc_i & stb_i & ~s_q.ack;
  assign wr  = req & we_i & sel_i[0];

  // divider terminal count for the selected system-clock source
  always_comb
  begin
    unique case (s_q.cks)
      ACC_CKS_DIV8:  tc = ACC_TC_DIV8;
      ACC_CKS_DIV16: tc = ACC_TC_DIV16;
      ACC_CKS_DIV32: tc = ACC_TC_DIV32;
      ACC_CKS_DIV64: tc = ACC_TC_DIV64;
      default:       tc = '0;
    endcase
  end

  assign rc_sel   = (s_q.cks[1:0] == ACC_CKS_RC);
  // reserved codes give no bit clock; system-clock sources stop in sleep
  assign fosc_run = (tc != '0) & ~sleep_i;

  // one pulse per bit period
  always_comb
  begin
    if (rc_sel)
    begin
      bit_tick = rc_tick_i & (s_q.rcdiv == ACC_TC_RC);
    end
    else
    begin
      bit_tick = fosc_run & (s_q.div == tc);
    end
  end

  // bit under decision: step 1 decides bit 9, step 10 decides bit 0
  assign idx  = 4'(ACC_LAST_STEP - s_q.step);
  // only a running conversion completes; an abort gap never sets the flag
  assign done = bit_tick & (s_q.state == ACC_CONV) & (s_q.step == ACC_LAST_STEP);

  always_comb
  begin
    s_d = s_q;

    // bit period dividers run only while a sequence needs them
    if (s_q.state == ACC_IDLE)
    begin
      s_d.div   = '0;
      s_d.rcdiv = '0;
    end
    else if (rc_sel)
    begin
      s_d.div = '0;
      if (rc_tick_i)
      begin
        s_d.rcdiv = s_q.rcdiv + 4'h1;
      end
    end
    else
    begin
      s_d.rcdiv = '0;
      if (bit_tick)
      begin
        s_d.div = '0;
      end
      else if (fosc_run)
      begin
        s_d.div = s_q.div + 6'h01;
      end
    end

    // sequencer
    unique case (s_q.state)
      ACC_IDLE:
      begin
        s_d.step = '0;
        s_d.gap  = '0;
      end
      ACC_CONV:
      begin
        if (bit_tick)
        begin
          s_d.step = s_q.step + 4'h1;
          if (s_q.step == '0)
          begin
            s_d.sar = '0;
            s_d.sar[ACC_RES_W-1] = 1'b1;
          end
          else
          begin
            s_d.sar[idx] = cmp_i;
            if (idx != '0)
            begin
              s_d.sar[idx-4'h1] = 1'b1;
            end
          end
        end
        if (done)
        begin
          s_d.state = ACC_IDLE;
          s_d.res   = s_d.sar;
        end
      end
      ACC_ABORT:
      begin
        if (bit_tick)
        begin
          s_d.gap = s_q.gap + 2'h1;
          if (s_q.gap == ACC_ABORT_GAP - 2'h1)
          begin
            s_d.state = ACC_IDLE;
          end
        end
      end
      default:
      begin
        s_d.state = ACC_IDLE;
      end
    endcase

    // register writes
    if (wr)
    begin
      unique case (adr_i)
        ACC_OFS_CTRL0:
        begin
          s_d.on = dat_i[ACC_ON_BIT];
          s_d.ch = dat_i[ACC_CH_LSB +: ACC_CH_W];
          if (dat_i[ACC_GO_BIT] && s_q.on && dat_i[ACC_ON_BIT] &&
              s_q.state == ACC_IDLE)
          begin
            s_d.state = ACC_CONV;
            s_d.step  = '0;
            s_d.div   = '0;
            s_d.rcdiv = '0;
          end
          else if (!dat_i[ACC_GO_BIT] && s_q.state == ACC_CONV && !done)
          begin
            s_d.state = ACC_ABORT;
            s_d.gap   = '0;
            s_d.div   = '0;
            s_d.rcdiv = '0;
            s_d.res   = s_q.res;
          end
        end
        ACC_OFS_CTRL1:
        begin
          s_d.cks = dat_i[ACC_CKS_LSB +: ACC_CKS_W];
        end
        ACC_OFS_IRQ:
        begin
          s_d.ie = dat_i[ACC_IE_BIT];
          if (!dat_i[ACC_FLAG_BIT])
          begin
            s_d.flag = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // turning the converter off cancels any sequence
    if (!s_d.on)
    begin
      s_d.state = ACC_IDLE;
    end

    // completion sets the flag; set wins over a same-cycle clear
    if (done && s_d.state == ACC_IDLE && s_d.on)
    begin
      s_d.flag = 1'b1;
    end
    else if (done)
    begin
      s_d.res = s_q.res;
    end

    // bus answer one cycle after the request
    s_d.ack = req;
    s_d.dat = '0;
    if (req && !we_i)
    begin
      unique case (adr_i)
        ACC_OFS_CTRL0:
        begin
          s_d.dat[ACC_ON_BIT] = s_q.on;
          s_d.dat[ACC_GO_BIT] = (s_q.state == ACC_CONV);
          s_d.dat[ACC_CH_LSB +: ACC_CH_W] = s_q.ch;
        end
        ACC_OFS_CTRL1:
        begin
          s_d.dat[ACC_CKS_LSB +: ACC_CKS_W] = s_q.cks;
        end
        ACC_OFS_RES_HI:
        begin
          s_d.dat[ACC_RES_HI_W-1:0] = s_q.res[ACC_RES_W-1:ACC_RES_LO_W];
        end
        ACC_OFS_RES_LO:
        begin
          s_d.dat[ACC_RES_LO_W-1:0] = s_q.res[ACC_RES_LO_W-1:0];
        end
        ACC_OFS_IRQ:
        begin
          s_d.dat[ACC_FLAG_BIT] = s_q.flag;
          s_d.dat[ACC_IE_BIT]   = s_q.ie;
        end
        default:
        begin
        end
      endcase
    end

    // interrupt, wake and vectoring requests
    s_d.irq  = s_d.flag & s_d.ie;
    s_d.wake = s_d.irq & sleep_i;
    s_d.vec  = s_d.irq & global_irq_enable_i
               & peripheral_irq_enable_i;

    // sample switch closes only when idle, so the abort gap delays acquisition
    s_d.acq  = s_d.on & (s_d.state == ACC_IDLE);
    s_d.hold = (s_d.state == ACC_CONV);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= ACC_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dat_o        = s_q.dat;
  assign ack_o        = s_q.ack;
  assign channel_o    = s_q.ch;
  assign trial_code_o = s_q.sar;
  assign power_o      = s_q.on;
  assign acquire_o    = s_q.acq;
  assign hold_o       = s_q.hold;
  assign irq_o        = s_q.irq;
  assign wake_o       = s_q.wake;
  assign vector_o     = s_q.vec;

endmodule

`default_nettype wire

/* File: bench/acc_top_chk.sv */
// acc_top_chk: port assertions for the converter control block
// bound to acc_top below; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module acc_top_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // converter
  input wire logic [4:0]  channel_o,
  input wire logic        power_o,
  input wire logic        acquire_o,
  input wire logic        hold_o,
  // system
  input wire logic        sleep_i,
  input wire logic        global_irq_enable_i,
  input wire logic        peripheral_irq_enable_i,
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; disable iff (1'b0) rst_i |=> !power_o && !hold_o && !wake_o; endproperty
  a_rst: assert property (p_rst) else $error("state kept through reset");
  property p_off; !power_o |-> !hold_o && !acquire_o; endproperty
  a_off: assert property (p_off) else $error("activity while disabled");
  property p_busy; hold_o |-> power_o && !acquire_o; endproperty
  a_busy: assert property (p_busy) else $error("acquire during conversion");
  property p_len; $rose(hold_o) |-> hold_o[*8]; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_chan; $changed(channel_o) |-> ack_o && $past(we_i); endproperty
  a_chan: assert property (p_chan) else $error("channel changed without write");
  property p_wake; wake_o |-> $past(sleep_i); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_vec; vector_o |-> $past(global_irq_enable_i && peripheral_irq_enable_i); endproperty
  a_vec: assert property (p_vec) else $error("vector without enables");
  property p_pad; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_pad: assert property (p_pad) else $error("upper read bits not zero");
  property p_irq; wake_o || vector_o |-> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("wake or vector without request");
endmodule
bind acc_top acc_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .dat_o(dat_o),
  .ack_o(ack_o), .channel_o(channel_o), .power_o(power_o), .acquire_o(acquire_o),
  .hold_o(hold_o), .sleep_i(sleep_i), .global_irq_enable_i(global_irq_enable_i),
  .peripheral_irq_enable_i(peripheral_irq_enable_i), .irq_o(irq_o), .wake_o(wake_o),
  .vector_o(vector_o));
`default_nettype wire

/* File: bench/tb.sv */
// tb: self-checking bench for acc_top
// acts as bus master, comparator and oscillator tick source
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic        cmp_i = 1'b0;
  logic        rc_tick_i = 1'b0;
  logic        sleep_i = 1'b0;
  logic        global_irq_enable_i = 1'b0;
  logic        peripheral_irq_enable_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, power_o, acquire_o, hold_o, irq_o, wake_o, vector_o;
  logic [4:0]  channel_o;
  logic [9:0]  trial_code_o;
  logic [9:0]  level = 10'h0;
  logic [1:0]  tick_cnt = 2'h0;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          tests_run = 0;
  acc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i),
    .rc_tick_i(rc_tick_i), .channel_o(channel_o), .trial_code_o(trial_code_o),
    .power_o(power_o), .acquire_o(acquire_o), .hold_o(hold_o), .sleep_i(sleep_i),
    .global_irq_enable_i(global_irq_enable_i),
    .peripheral_irq_enable_i(peripheral_irq_enable_i), .irq_o(irq_o),
    .wake_o(wake_o), .vector_o(vector_o));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  // analog input model and one oscillator tick every third cycle
  always @(posedge clk_i)
  begin
    cmp_i <= (level >= trial_code_o);
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    rc_tick_i <= (tick_cnt == 2'h2);
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    check("ack wait", 2, n);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    check("ack drop", 0, ack_o);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(what, {24'h0, exp}, rd);
  endtask
  task automatic conv(input logic [2:0] cks, input int per, input logic [9:0] lvl);
    int n;
    level <= lvl;
    wb(1'b1, ACC_OFS_CTRL1, {1'b0, cks, 4'h0});
    wb(1'b1, ACC_OFS_CTRL0, 8'h61);
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    n = 1;
    while (hold_o === 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    check("length", 1, n + 2 >= 11 * per && n <= 11 * per);
    rdchk("go", ACC_OFS_CTRL0, 8'h61);
    rdchk("res_hi", ACC_OFS_RES_HI, {6'h0, lvl[9:8]});
    rdchk("res_lo", ACC_OFS_RES_LO, lvl[7:0]);
    rdchk("flag", ACC_OFS_IRQ, 8'h01);
    check("irq", 0, irq_o);
  endtask
  task automatic t_bits;
    for (int a = 0; a <= 'h14; a += 4) rdchk("reset", a[7:0], 8'h00);
    wb(1'b1, ACC_OFS_CTRL1, 8'hff);
    rdchk("ctrl1", ACC_OFS_CTRL1, 8'h70);
    wb(1'b1, ACC_OFS_CTRL0, 8'hff);
    rdchk("ctrl0", ACC_OFS_CTRL0, 8'h7d);
    check("chan", 5'h1f, channel_o);
    check("power", 1, power_o);
    wb(1'b1, ACC_OFS_RES_LO, 8'hff);
    rdchk("res_lo ro", ACC_OFS_RES_LO, 8'h00);
    wb(1'b1, ACC_OFS_CTRL0, 8'h00);
    check("power off", 0, power_o);
  endtask
  task automatic t_codes;
    logic [2:0] cks [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int         per [6] = '{8, 16, 32, 64, 48, 48};
    logic [9:0] lvl [6] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a, 10'h201, 10'h1fe};
    for (int i = 0; i < 6; i++)
    begin
      conv(cks[i], per[i], lvl[i]);
      wb(1'b1, ACC_OFS_IRQ, 8'h00);
    end
  endtask
  task automatic t_abort;
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    repeat (40) @(posedge clk_i);
    wb(1'b1, ACC_OFS_CTRL0, 8'h61);
    check("acquire gap", 0, acquire_o);
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    rdchk("gap go", ACC_OFS_CTRL0, 8'h61);
    rdchk("kept lo", ACC_OFS_RES_LO, 8'hfe);
    rdchk("no flag", ACC_OFS_IRQ, 8'h00);
    repeat (60) @(posedge clk_i);
    check("gap hold", 0, acquire_o);
    repeat (30) @(posedge clk_i);
    check("acquire", 1, acquire_o);
    // abort in the last bit period of a divide-by-8 conversion
    wb(1'b1, ACC_OFS_CTRL1, 8'h10);
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    repeat (80) @(posedge clk_i);
    wb(1'b1, ACC_OFS_CTRL0, 8'h61);
    check("late gap", 0, acquire_o);
    repeat (20) @(posedge clk_i);
    rdchk("late abort flag", ACC_OFS_IRQ, 8'h00);
    rdchk("late abort hi", ACC_OFS_RES_HI, 8'h01);
    // reserved clock code stalls until the converter is switched off
    wb(1'b1, ACC_OFS_CTRL1, 8'h00);
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    repeat (100) @(posedge clk_i);
    rdchk("stall go", ACC_OFS_CTRL0, 8'h63);
    wb(1'b1, ACC_OFS_CTRL0, 8'h00);
    check("off cancel", 0, hold_o);
    rdchk("off go", ACC_OFS_CTRL0, 8'h00);
  endtask
  task automatic t_sleep;
    sleep_i <= 1'b1;
    conv(3'h3, 48, 10'h2c3);
    wb(1'b1, ACC_OFS_IRQ, 8'h03);
    repeat (3) @(posedge clk_i);
    check("irq", 1, irq_o);
    check("wake", 1, wake_o);
    check("no vector", 0, vector_o);
    global_irq_enable_i <= 1'b1;
    peripheral_irq_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("vector", 1, vector_o);
    wb(1'b1, ACC_OFS_IRQ, 8'h00);
    check("irq clr", 0, irq_o);
    wb(1'b1, ACC_OFS_CTRL1, 8'h10);
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    repeat (200) @(posedge clk_i);
    rdchk("sleep stall", ACC_OFS_CTRL0, 8'h63);
    sleep_i <= 1'b0;
    repeat (120) @(posedge clk_i);
    rdchk("late flag", ACC_OFS_IRQ, 8'h01);
  endtask
  task automatic t_reset;
    wb(1'b1, ACC_OFS_CTRL0, 8'h63);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset hold", 0, hold_o);
    check("reset power", 0, power_o);
    rdchk("reset ctrl0", ACC_OFS_CTRL0, 8'h00);
    rdchk("reset ctrl1", ACC_OFS_CTRL1, 8'h00);
    rdchk("reset hi", ACC_OFS_RES_HI, 8'h00);
    rdchk("reset flag", ACC_OFS_IRQ, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_bits;
    t_codes;
    t_abort;
    t_sleep;
    t_reset;
    tally_and_finish;
  end
endmodule
`default_nettype wire
